// >>> src/strap_pkg.sv
// constants for the strap option sampler
package strap_pkg;

    // register indices as printed; the apb byte address is four times the index
    localparam logic [7:0]  IDX_INTERFACE_SELECT = 8'h3c;
    localparam logic [7:0]  IDX_PANEL_SUPPLY     = 8'h3d;
    localparam logic [7:0]  IDX_BANK01           = 8'h4a;
    localparam logic [7:0]  IDX_BANK23           = 8'h4b;
    localparam logic [7:0]  IDX_CLOCK_SOURCE     = 8'h4c;
    localparam logic [7:0]  IDX_HOST_SYNTH       = 8'h5f;
    localparam int          ADDR_W               = 12;

    // memory data line positions feeding each register
    localparam int          MD_BANK01_LSB        = 0;
    localparam int          MD_BANK23_LSB        = 8;
    localparam int          MD_CLOCK_LSB         = 16;
    localparam int          MD_CLOCK_HI          = 23;
    localparam int          MD_SYNTH_LSB         = 21;
    localparam int          MD_IFSEL_LSB         = 40;
    localparam int          MD_PANEL_LSB         = 48;
    localparam int          MD_WIDTH             = 64;

    // clock_source_straps fields
    localparam int          CLK_PCI_DIV_BIT      = 1;
    localparam int          CLK_HOST_PAD_BIT     = 2;
    localparam int          CLK_GFX_PAD_BIT      = 3;
    localparam int          CLK_DOT_PAD_BIT      = 4;
    localparam logic [7:0]  CLK_WRITE_MASK       = 8'h10;
    localparam logic [7:0]  CLK_READ_MASK        = 8'h3f;

    // host_synth_straps fields
    localparam int          SYN_DEBUG_BIT        = 1;
    localparam int          SYN_CODE_LSB         = 3;
    localparam logic [7:0]  SYN_READ_MASK        = 8'h3f;

    // interface_select_straps fields
    localparam int          IF_PCCARD_BIT        = 0;
    localparam int          IF_LOCAL_BUS_BIT     = 1;
    localparam int          IF_KBD_MOUSE_BIT     = 2;
    localparam int          IF_PARALLEL_BIT      = 3;
    localparam int          IF_SERIAL1_BIT       = 4;
    localparam int          IF_SERIAL2_BIT       = 5;

    // panel_and_socket_supply_straps fields
    localparam int          PS_PANEL_BIT         = 0;
    localparam int          PS_SUPPLY_LSB        = 1;
    localparam logic [7:0]  PS_READ_MASK         = 8'h3f;

    // pci clock divisors
    localparam logic [1:0]  PCI_DIV_SLOW         = 2'h3;
    localparam logic [1:0]  PCI_DIV_FAST         = 2'h2;

    // cycles after reset release before the synchronised straps are valid
    localparam logic [1:0]  SETTLE_CYCLES        = 2'h2;

    localparam int          SPARE_PADS           = 12;

    typedef enum logic [1:0] {
        CAP_SETTLE = 2'b00,
        CAP_TAKE   = 2'b01,
        CAP_HOLD   = 2'b10
    } cap_state_t;

    // host synthesiser frequency in mhz for a three-bit code
    function automatic logic [6:0] synth_mhz(input logic [2:0] code);
        case (code)
            3'h0:    synth_mhz = 7'd25;
            3'h1:    synth_mhz = 7'd33;
            3'h2:    synth_mhz = 7'd40;
            3'h3:    synth_mhz = 7'd50;
            3'h4:    synth_mhz = 7'd60;
            3'h5:    synth_mhz = 7'd66;
            3'h6:    synth_mhz = 7'd75;
            default: synth_mhz = 7'd80;
        endcase
    endfunction : synth_mhz

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'h0, idx, 2'h0};
    endfunction : byte_addr

endpackage : strap_pkg

// >>> src/strap_sync.sv
// two flip-flop synchroniser for a bus of pin levels
`timescale 1ns/1ps
module strap_sync #(
    parameter int WIDTH = 64
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;

    if (WIDTH < 1) begin : g_bad_width
        $error("strap_sync width must be positive");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            dout   <= '0;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : strap_sync

// >>> src/pci_clock_divider.sv
// divides the host clock by two or three for the pci clock output
`timescale 1ns/1ps
module pci_clock_divider
    import strap_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic [1:0] divisor,
    output logic            clk_out
);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       out_nxt;

    always_comb begin
        cnt_nxt = 2'h0;
        if (run && (cnt_r < divisor - 2'h1)) begin
            cnt_nxt = cnt_r + 2'h1;
        end
        // high for one host clock per period
        out_nxt = run && (cnt_nxt == 2'h0);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= 2'h0;
            clk_out <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            clk_out <= out_nxt;
        end
    end
endmodule : pci_clock_divider

// >>> src/strap_option_sampler.sv
// strap option sampler: captures memory data line straps at reset, apb readback
// What this block and its board must do
// R1 - pci clock is host clock /3 or /2
// R2 - host clock pad input or driven internally
// R3 - graphics double clock source external or internal
// R4 - pixel dot clock source external or internal
// R5 - three-bit code picks host synthesiser frequency
// R6 - peripheral controller debug external or internal
// R7 - two-bit speed hint per memory bank
// R8 - one-bit edo/fast-page type hint per bank
// R9 - shared pins carry pci or pc-card
// R10 - shared pins carry isa or local bus
// R11 - keyboard, parallel, serial ports internal or external
// R12 - panel outputs on spare pads only when enabled
// R13 - card-socket supply availability reported per voltage
// R14 - board pulls up upper speed-hint lines
// R15 - board ties reserved strap lines as prescribed
// R16 - straps are pulls sampled during reset; this block samples them after reset release
// R17 - only dot clock bit is software writable
// R18 - memory hints are informational, no hardware effect
// R19 - capture once after reset, then hold
`timescale 1ns/1ps
module strap_option_sampler
    import strap_pkg::*;
#(
    parameter int MD_W = MD_WIDTH
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // strap levels on the memory data bus
    input  wire logic [MD_W-1:0]         memory_data_line,
    // panel low colour bits offered to the spare pads
    input  wire logic [SPARE_PADS-1:0]   panel_low_bits,
    // apb slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // configuration outputs
    output logic                         straps_valid,
    output logic                         pci_clock_out,
    output logic                         host_clock_pad_oe_n,
    output logic                         graphics_double_clock_internal,
    output logic                         pixel_dot_clock_internal,
    output logic      [2:0]              host_synth_code,
    output logic      [6:0]              host_synth_mhz,
    output logic                         peripheral_controller_internal,
    output logic                         pccard_selected,
    output logic                         local_bus_selected,
    output logic                         kbd_mouse_internal,
    output logic                         parallel_port_internal,
    output logic                         first_serial_port_internal,
    output logic                         second_serial_port_internal,
    output logic      [SPARE_PADS-1:0]   spare_pad_out,
    output logic      [SPARE_PADS-1:0]   spare_pad_oe_n,
    output logic      [3:0]              socket_supply_available
);

    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // the strap map reaches up to the panel supply byte
    if (MD_W < MD_PANEL_LSB + 8) begin : g_md_narrow
        $error("memory data bus too narrow for the strap map");
    end

    // a zero settle count would wrap the counter and stretch the settle time
    if (SETTLE_CYCLES == 2'h0) begin : g_settle_zero
        $error("settle count must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisation

    logic            rst_meta_r;
    logic            rst_sync_n;
    logic [MD_W-1:0] md_sync;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    strap_sync #(
        .WIDTH (MD_W)
    ) u_md_sync (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .din   (memory_data_line),
        .dout  (md_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // capture sequence

    // md_sync lags the pins by two cycles; settling lets it fill before the take
    cap_state_t state_r;
    cap_state_t state_nxt;
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;

    always_comb begin
        state_nxt  = state_r;
        settle_nxt = settle_r;
        case (state_r)
            CAP_SETTLE: begin
                settle_nxt = settle_r + 2'h1;
                if (settle_r == SETTLE_CYCLES - 2'h1) begin
                    state_nxt = CAP_TAKE;
                end
            end
            CAP_TAKE: state_nxt = CAP_HOLD;
            CAP_HOLD: state_nxt = CAP_HOLD;                        // [R19]
            default:  state_nxt = CAP_SETTLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_r  <= CAP_SETTLE;
            settle_r <= 2'h0;
        end else begin
            state_r  <= state_nxt;
            settle_r <= settle_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap registers

    logic [7:0] ifsel_r,  ifsel_nxt;
    logic [7:0] panel_r,  panel_nxt;
    logic [7:0] bank01_r, bank01_nxt;
    logic [7:0] bank23_r, bank23_nxt;
    logic [7:0] clksrc_r, clksrc_nxt;
    logic [7:0] synth_r,  synth_nxt;
    logic       take;
    logic       wr_clk;

    assign take   = (state_r == CAP_TAKE);
    assign wr_clk = psel && penable && pready && pwrite && pstrb[0]
                    && (paddr == byte_addr(IDX_CLOCK_SOURCE));

    always_comb begin
        ifsel_nxt  = ifsel_r;
        panel_nxt  = panel_r;
        bank01_nxt = bank01_r;
        bank23_nxt = bank23_r;
        clksrc_nxt = clksrc_r;
        synth_nxt  = synth_r;
        // a capture outranks a software write landing in the same cycle
        if (take) begin                                             // [R16] [R19]
            bank01_nxt = md_sync[MD_BANK01_LSB +: 8];               // [R7] [R8]
            bank23_nxt = md_sync[MD_BANK23_LSB +: 8];               // [R7] [R8]
            clksrc_nxt = {2'h0, md_sync[MD_CLOCK_HI], md_sync[MD_CLOCK_LSB +: 5]};
            synth_nxt  = {2'h0, md_sync[MD_SYNTH_LSB +: 6]};
            ifsel_nxt  = md_sync[MD_IFSEL_LSB +: 8];
            panel_nxt  = {2'h0, md_sync[MD_PANEL_LSB +: 6]};
        end else if (wr_clk) begin
            // only the dot clock source bit takes software writes
            clksrc_nxt = (clksrc_r & ~CLK_WRITE_MASK) | (pwdata[7:0] & CLK_WRITE_MASK); // [R17]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ifsel_r  <= 8'h00;
            panel_r  <= 8'h00;
            bank01_r <= 8'h00;
            bank23_r <= 8'h00;
            clksrc_r <= 8'h00;
            synth_r  <= 8'h00;
        end else begin
            ifsel_r  <= ifsel_nxt;
            panel_r  <= panel_nxt;
            bank01_r <= bank01_nxt;
            bank23_r <= bank23_nxt;
            clksrc_r <= clksrc_nxt;
            synth_r  <= synth_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, answer registered

    logic [31:0] prdata_nxt;
    logic        pready_nxt;
    logic        pslverr_nxt;
    logic        mapped;
    logic [7:0]  rd_byte;

    // answer prepared on the first access edge, pready stands for one cycle
    always_comb begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            byte_addr(IDX_INTERFACE_SELECT): rd_byte = ifsel_r;
            byte_addr(IDX_PANEL_SUPPLY):     rd_byte = panel_r & PS_READ_MASK;
            byte_addr(IDX_BANK01):           rd_byte = bank01_r;    // [R18]
            byte_addr(IDX_BANK23):           rd_byte = bank23_r;    // [R18]
            byte_addr(IDX_CLOCK_SOURCE):     rd_byte = clksrc_r & CLK_READ_MASK;
            byte_addr(IDX_HOST_SYNTH):       rd_byte = synth_r & SYN_READ_MASK;
            default:                         mapped  = 1'b0;
        endcase
        pready_nxt  = 1'b0;
        pslverr_nxt = 1'b0;
        prdata_nxt  = prdata;
        if (psel && penable && !pready) begin
            pready_nxt  = 1'b1;
            pslverr_nxt = !mapped;
            prdata_nxt  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration outputs; memory hints deliberately drive nothing

    logic                  held;
    logic [1:0]            pci_div;
    logic [SPARE_PADS-1:0] spare_out_nxt;
    logic [SPARE_PADS-1:0] spare_oe_n_nxt;

    assign held    = (state_r == CAP_HOLD);
    assign pci_div = clksrc_r[CLK_PCI_DIV_BIT] ? PCI_DIV_FAST : PCI_DIV_SLOW; // [R1]

    pci_clock_divider u_pci_div (
        .clk     (clk),
        .rst_n   (rst_sync_n),
        .run     (held),
        .divisor (pci_div),
        .clk_out (pci_clock_out)
    );

    always_comb begin
        spare_out_nxt  = '0;
        spare_oe_n_nxt = '1;
        if (held && panel_r[PS_PANEL_BIT]) begin                    // [R12]
            spare_out_nxt  = panel_low_bits;
            spare_oe_n_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            straps_valid                   <= 1'b0;
            host_clock_pad_oe_n            <= 1'b1;
            graphics_double_clock_internal <= 1'b0;
            pixel_dot_clock_internal       <= 1'b0;
            host_synth_code                <= 3'h0;
            host_synth_mhz                 <= 7'h00;
            peripheral_controller_internal <= 1'b0;
            pccard_selected                <= 1'b0;
            local_bus_selected             <= 1'b0;
            kbd_mouse_internal             <= 1'b0;
            parallel_port_internal         <= 1'b0;
            first_serial_port_internal     <= 1'b0;
            second_serial_port_internal    <= 1'b0;
            spare_pad_out                  <= '0;
            spare_pad_oe_n                 <= '1;
            socket_supply_available        <= 4'h0;
        end else begin
            straps_valid                   <= held;
            host_clock_pad_oe_n            <= !(held && clksrc_r[CLK_HOST_PAD_BIT]); // [R2]
            graphics_double_clock_internal <= clksrc_r[CLK_GFX_PAD_BIT];   // [R3]
            pixel_dot_clock_internal       <= clksrc_r[CLK_DOT_PAD_BIT];   // [R4]
            host_synth_code                <= synth_r[SYN_CODE_LSB +: 3];  // [R5]
            host_synth_mhz                 <= synth_mhz(synth_r[SYN_CODE_LSB +: 3]); // [R5]
            peripheral_controller_internal <= synth_r[SYN_DEBUG_BIT];      // [R6]
            pccard_selected                <= ifsel_r[IF_PCCARD_BIT];      // [R9]
            local_bus_selected             <= ifsel_r[IF_LOCAL_BUS_BIT];   // [R10]
            kbd_mouse_internal             <= ifsel_r[IF_KBD_MOUSE_BIT];   // [R11]
            parallel_port_internal         <= ifsel_r[IF_PARALLEL_BIT];    // [R11]
            first_serial_port_internal     <= ifsel_r[IF_SERIAL1_BIT];     // [R11]
            second_serial_port_internal    <= ifsel_r[IF_SERIAL2_BIT];     // [R11]
            spare_pad_out                  <= spare_out_nxt;
            spare_pad_oe_n                 <= spare_oe_n_nxt;
            socket_supply_available        <= panel_r[PS_SUPPLY_LSB +: 4]; // [R13]
        end
    end

endmodule : strap_option_sampler

// >>> test/strap_option_sampler_assertions.sv
// concurrent checks on the strap option sampler ports
`timescale 1ns/1ps
module strap_option_sampler_assertions
    import strap_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire logic                  straps_valid,
    input wire logic                  pci_clock_out,
    input wire logic                  host_clock_pad_oe_n,
    input wire logic [2:0]            host_synth_code,
    input wire logic [6:0]            host_synth_mhz,
    input wire logic                  pccard_selected,
    input wire logic [SPARE_PADS-1:0] panel_low_bits,
    input wire logic [SPARE_PADS-1:0] spare_pad_out,
    input wire logic [SPARE_PADS-1:0] spare_pad_oe_n,
    input wire logic [3:0]            socket_supply_available
);
    localparam logic [6:0] MHZ [8] = '{7'h19, 7'h21, 7'h28, 7'h32, 7'h3c, 7'h42, 7'h4b, 7'h50};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    sequence access_wait;
        psel && penable && !pready;
    endsequence
    sequence pci_gap;
        !pci_clock_out ##[1:2] pci_clock_out;
    endsequence
    sequence settled;
        straps_valid [*3];
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    a_ready_after_access: assert property (access_wait |=> pready)
        else $error("pready missing after access phase");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_zero_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error response carries data");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bytes not zero");
    a_valid_held: assert property (straps_valid |=> straps_valid)
        else $error("straps valid dropped");
    a_config_held: assert property (settled |-> $stable({pccard_selected, host_synth_code,
        socket_supply_available, host_clock_pad_oe_n})) else $error("captured config changed");
    a_synth_map: assert property (settled |-> host_synth_mhz == MHZ[host_synth_code])
        else $error("synth frequency does not match code");
    a_pci_spacing: assert property (pci_clock_out |=> pci_gap)
        else $error("pci clock pulse spacing wrong");
    a_spare_off: assert property (spare_pad_oe_n[0] |-> spare_pad_out == '0 && spare_pad_oe_n == '1)
        else $error("spare pads active while disabled");
    a_spare_pass: assert property (!spare_pad_oe_n[0] ##1 !spare_pad_oe_n[0]
        |-> spare_pad_out == $past(panel_low_bits)) else $error("spare pads do not follow panel bits");
endmodule : strap_option_sampler_assertions

bind strap_option_sampler strap_option_sampler_assertions u_chk (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .straps_valid(straps_valid), .pci_clock_out(pci_clock_out),
    .host_clock_pad_oe_n(host_clock_pad_oe_n), .host_synth_code(host_synth_code),
    .host_synth_mhz(host_synth_mhz), .pccard_selected(pccard_selected), .panel_low_bits(panel_low_bits),
    .spare_pad_out(spare_pad_out), .spare_pad_oe_n(spare_pad_oe_n),
    .socket_supply_available(socket_supply_available)
);

// >>> test/strap_board_model.sv
// board pull resistors and user jumpers on the memory data lines
`timescale 1ns/1ps
module strap_board_model #(
    parameter logic [63:0] PULL_UP   = 64'h0520_00fa_00a0_4848,
    parameter logic [63:0] PULL_DOWN = 64'h0a00_c005_f800_0000
) (
    input  wire logic [63:0] user_straps,
    output logic      [63:0] memory_data_line
);
    // upper speed lines and reserved lines are fixed by resistors, the rest follow jumpers
    assign memory_data_line = (user_straps & ~PULL_DOWN) | PULL_UP;
endmodule : strap_board_model

// >>> test/strap_option_sampler_tb.sv
// self-checking bench for the strap option sampler
`timescale 1ns/1ps
module strap_option_sampler_tb;
    import strap_pkg::*;
    typedef struct packed {logic wr; logic err; logic [31:0] data;} note_t;
    localparam logic [6:0] MHZ [8] = '{7'h19, 7'h21, 7'h28, 7'h32, 7'h3c, 7'h42, 7'h4b, 7'h50};

    logic                  clk, rst_n, psel, penable, pwrite, pready, pslverr, straps_valid, pci_clk;
    logic [63:0]           user_straps, md;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata;
    logic [3:0]            pstrb, socket;
    logic [SPARE_PADS-1:0] panel, spare_out, spare_oe_n;
    logic [2:0]            synth_code;
    logic [6:0]            synth_mhz;
    logic                  host_oe_n, gfx_int, dot_int, pc_int, pccard, lbus, kbd, par, ser1, ser2;
    logic [7:0]            exp4c;
    note_t                 notes[$];
    note_t                 seen_n;
    int                    error_cnt, checks;

    strap_board_model board (.user_straps(user_straps), .memory_data_line(md));

    strap_option_sampler dut (
        .clk(clk), .rst_n(rst_n), .memory_data_line(md), .panel_low_bits(panel), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .straps_valid(straps_valid), .pci_clock_out(pci_clk),
        .host_clock_pad_oe_n(host_oe_n), .graphics_double_clock_internal(gfx_int),
        .pixel_dot_clock_internal(dot_int), .host_synth_code(synth_code), .host_synth_mhz(synth_mhz),
        .peripheral_controller_internal(pc_int), .pccard_selected(pccard), .local_bus_selected(lbus),
        .kbd_mouse_internal(kbd), .parallel_port_internal(par), .first_serial_port_internal(ser1),
        .second_serial_port_internal(ser2), .spare_pad_out(spare_out), .spare_pad_oe_n(spare_oe_n),
        .socket_supply_available(socket)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    function automatic logic [11:0] ba(input logic [7:0] idx);
        ba = {2'h0, idx, 2'h0};
    endfunction : ba

    // one apb transfer; the expected answer is queued for the monitor
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [31:0] ed, input logic ee);
        int n;
        notes.push_back('{w, ee, ed});
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            error_cnt++;
            wrap_up();
        end
    endtask : apb

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, ba(idx), $urandom, 4'hf, {24'h0, exp}, 1'b0);
    endtask : rd

    // board jumpers change only while reset is held
    task automatic start_run(input logic [2:0] code);
        logic [63:0] u;
        int          n;
        u = {$urandom, $urandom};
        u[26:24] = code;
        @(posedge clk);
        rst_n       <= 1'b0;
        user_straps <= u;
        panel       <= 12'($urandom);
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        n = 0;
        while (straps_valid !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40) begin
            error_cnt++;
            wrap_up();
        end
        repeat (2) @(posedge clk);
        exp4c = {2'h0, md[23], md[20:16]};
    endtask : start_run

    task automatic check_all();
        logic [31:0] so, eo, hi;
        panel <= 12'($urandom);
        rd(IDX_INTERFACE_SELECT, md[47:40]);
        rd(IDX_PANEL_SUPPLY, {2'h0, md[53:48]});
        rd(IDX_BANK01, md[7:0]);
        rd(IDX_BANK23, md[15:8]);
        rd(IDX_CLOCK_SOURCE, exp4c);
        rd(IDX_HOST_SYNTH, {2'h0, md[26:21]});
        so = {18'h0, host_oe_n, gfx_int, dot_int, pc_int, pccard, lbus, kbd, par, ser1, ser2, socket};
        eo = {18'h0, ~md[18], md[19], exp4c[4], md[22], md[40], md[41], md[42], md[43], md[44], md[45], md[52:49]};
        check(so, eo);
        check({22'h0, synth_code, synth_mhz}, {22'h0, md[26:24], MHZ[md[26:24]]});
        eo = md[48] ? {8'h0, panel, 12'h0} : {20'h0, 12'hfff};
        check({8'h0, spare_out, spare_oe_n}, eo);
        hi = 32'h0;
        repeat (12) begin
            @(posedge clk);
            hi = hi + {31'h0, pci_clk};
        end
        check(hi, md[17] ? 32'h6 : 32'h4);
    endtask : check_all

    // takes the oldest note at every completed transfer
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) check(32'h1, 32'h0);
            else begin
                seen_n = notes.pop_front();
                check({31'h0, pslverr}, {31'h0, seen_n.err});
                if (!seen_n.wr) check(prdata, seen_n.data);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        user_straps = '0;
        panel = '0;
        exp4c = '0;
        error_cnt = 0;
        checks = 0;
        void'($urandom(95154));
        for (int k = 0; k < 8; k++) begin
            start_run(3'(k));
            check_all();
        end
        apb(1'b1, ba(IDX_CLOCK_SOURCE), {24'h0, ~exp4c}, 4'hf, 32'h0, 1'b0);
        exp4c[4] = ~exp4c[4];
        apb(1'b1, ba(IDX_CLOCK_SOURCE), {24'h0, ~exp4c}, 4'he, 32'h0, 1'b0);
        apb(1'b1, ba(IDX_INTERFACE_SELECT), {24'h0, ~md[47:40]}, 4'hf, 32'h0, 1'b0);
        apb(1'b1, ba(IDX_HOST_SYNTH), 32'hffff_ffff, 4'hf, 32'h0, 1'b0);
        apb(1'b0, 12'h004, 32'h0, 4'hf, 32'h0, 1'b1);
        check_all();
        wrap_up();
    end
endmodule : strap_option_sampler_tb
